//--- vfdcd_params.svh
// Constants of the display command decoder: command codes, fields, timing.
`ifndef VFDCD_PARAMS_SVH
`define VFDCD_PARAMS_SVH
`define VFDCD_CMD_INC 8'h04
`define VFDCD_CMD_NOINC 8'h05
`define VFDCD_CMD_WRITE 8'h08
`define VFDCD_CMD_READ 8'h09
`define VFDCD_CMD_SA1_LO 8'h0a
`define VFDCD_CMD_SA1_HI 8'h0b
`define VFDCD_CMD_SA2_LO 8'h0c
`define VFDCD_CMD_SA2_HI 8'h0d
`define VFDCD_CMD_CUR_LO 8'h0e
`define VFDCD_CMD_CUR_HI 8'h0f
`define VFDCD_LUM_BASE 8'h18
`define VFDCD_LUM_MASK 8'hfc
`define VFDCD_ADDR_W 13
`define VFDCD_LO_W 8
`define VFDCD_HI_W 5
`define VFDCD_LUM_RESET 2'h0
`define VFDCD_CLK_MHZ 20
`define VFDCD_GAP_NS 2000
`define VFDCD_GAP_CYC ((`VFDCD_GAP_NS * `VFDCD_CLK_MHZ + 999) / 1000)
`define VFDCD_FRAME_CYC 20000
`define VFDCD_REG_CTRL 32'h0000_0000
`define VFDCD_REG_DATA 32'h0000_0004
`define VFDCD_REG_STAT 32'h0000_0008
`define VFDCD_REG_RDATA 32'h0000_000c
`endif

//--- vfdcd_pkg.sv
// Types of the host end of the display command decoder link.
package vfdcd_pkg;
    typedef enum logic [1:0] {
        VFDCD_H_IDLE = 2'b00,
        VFDCD_H_STROBE = 2'b01,
        VFDCD_H_GAP = 2'b10
    } vfdcd_hstate_t;
endpackage

//--- vfdcd_if.sv
// Parallel host port between the host controller and the display decoder.
`timescale 1ns/1ps
interface vfdcd_if;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic cmd_sel;
    logic [7:0] d_host;
    logic d_host_oe;
    logic [7:0] d_dev;
    logic d_dev_oe;
    logic blank_n;
    logic frame_pulse;
    logic [7:0] d_bus;
    assign d_bus = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'h00);
    modport device (input cs_n, wr_n, rd_n, cmd_sel, d_bus, blank_n,
        output d_dev, d_dev_oe, frame_pulse);
    modport host (output cs_n, wr_n, rd_n, cmd_sel, d_host, d_host_oe, blank_n,
        input d_bus, frame_pulse);
endinterface

//--- vfdcd_device.sv
// Display end: command decoder, cursor and start addresses, RAM, luminance, frame.
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "vfdcd_params.svh"
module vfdcd_device
    import vfdcd_pkg::*;
#(
    parameter int ADDR_W = `VFDCD_ADDR_W,
    parameter int FRAME_CYC = `VFDCD_FRAME_CYC,
    parameter int SCAN_W = 11
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Host port.
    vfdcd_if.device port,
    // Display side.
    output logic [ADDR_W-1:0] start1,
    output logic [ADDR_W-1:0] start2,
    output logic [1:0] lum_level,
    output logic display_on,
    output logic [7:0] pixel_byte,
    output logic [ADDR_W-1:0] scan_addr
);
    localparam int DEPTH = 1 << ADDR_W;
    typedef enum logic [3:0] {
        VFDCD_T_NONE = 4'h0,
        VFDCD_T_WRITE = 4'h1,
        VFDCD_T_READ = 4'h2,
        VFDCD_T_SA1_LO = 4'h3,
        VFDCD_T_SA1_HI = 4'h4,
        VFDCD_T_SA2_LO = 4'h5,
        VFDCD_T_SA2_HI = 4'h6,
        VFDCD_T_CUR_LO = 4'h7,
        VFDCD_T_CUR_HI = 4'h8
    } vfdcd_target_t;

    logic [7:0] ram [DEPTH];
    logic wr_q;
    logic rd_q;
    logic wr_rise;
    logic rd_fall;
    logic rd_rise;
    logic cmd_stb;
    logic data_stb;
    logic rd_stb;
    vfdcd_target_t target_q;
    logic auto_inc_q;
    logic [ADDR_W-1:0] cursor_q;
    logic [7:0] stage_q;
    logic [7:0] rd_latch_q;
    logic [7:0] dout_q;
    localparam int FCW = $clog2(FRAME_CYC);
    logic [FCW-1:0] frame_cnt_q;
    logic cs_q;
    logic sel_q;
    logic [7:0] byte_q;
    logic cur_lo_valid_q;
    logic [SCAN_W-1:0] scan_cnt_q;
    logic data_access;

    // Strobe edges. The host lifts chip select and the byte with the strobe, so
    // the qualifiers and the byte are taken as they stood in the last strobe cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            cs_q <= 1'b1;
            sel_q <= 1'b0;
            byte_q <= 8'h00;
        end else begin
            wr_q <= port.wr_n;
            rd_q <= port.rd_n;
            cs_q <= port.cs_n;
            sel_q <= port.cmd_sel;
            byte_q <= port.d_bus;
        end
    end
    assign wr_rise = !wr_q && port.wr_n;
    assign rd_fall = rd_q && !port.rd_n;
    assign rd_rise = !rd_q && port.rd_n;
    assign cmd_stb = wr_rise && !cs_q && sel_q;
    assign data_stb = wr_rise && !cs_q && !sel_q;
    assign rd_stb = rd_rise && !cs_q && !sel_q;

    // Command decode picks what the following data bytes mean.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            target_q <= VFDCD_T_NONE;
            auto_inc_q <= 1'b1;
            lum_level <= `VFDCD_LUM_RESET;
        end else if (cmd_stb) begin
            case (byte_q)
                `VFDCD_CMD_INC: auto_inc_q <= 1'b1;
                `VFDCD_CMD_NOINC: auto_inc_q <= 1'b0;
                `VFDCD_CMD_WRITE: target_q <= VFDCD_T_WRITE;
                `VFDCD_CMD_READ: target_q <= VFDCD_T_READ;
                `VFDCD_CMD_SA1_LO: target_q <= VFDCD_T_SA1_LO;
                `VFDCD_CMD_SA1_HI: target_q <= VFDCD_T_SA1_HI;
                `VFDCD_CMD_SA2_LO: target_q <= VFDCD_T_SA2_LO;
                `VFDCD_CMD_SA2_HI: target_q <= VFDCD_T_SA2_HI;
                `VFDCD_CMD_CUR_LO: target_q <= VFDCD_T_CUR_LO;
                `VFDCD_CMD_CUR_HI: target_q <= VFDCD_T_CUR_HI;
                default: begin
                    // Codes outside the set change nothing, except luminance codes, which set lum_level.
                    if ((byte_q & `VFDCD_LUM_MASK) == `VFDCD_LUM_BASE) begin
                        lum_level <= byte_q[1:0];
                    end
                end
            endcase
        end
    end

    assign data_access = (data_stb && target_q == VFDCD_T_WRITE) ||
        (rd_stb && target_q == VFDCD_T_READ);

    // Lower bytes wait in a stage so a half-written address never takes effect.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_q <= 8'h00;
            start1 <= '0;
            start2 <= '0;
        end else if (data_stb) begin
            case (target_q)
                VFDCD_T_SA1_LO, VFDCD_T_SA2_LO, VFDCD_T_CUR_LO: stage_q <= byte_q;
                VFDCD_T_SA1_HI: start1 <= {byte_q[`VFDCD_HI_W-1:0], stage_q};
                VFDCD_T_SA2_HI: start2 <= {byte_q[`VFDCD_HI_W-1:0], stage_q};
                default: stage_q <= stage_q;
            endcase
        end
    end

    // Cursor counter: loaded by the upper byte, stepped per data byte.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cursor_q <= '0;
        end else if (data_stb && target_q == VFDCD_T_CUR_HI) begin
            // An upper-only write keeps the counter's own lower byte.
            cursor_q <= {byte_q[`VFDCD_HI_W-1:0],
                (cur_lo_valid_q ? stage_q : cursor_q[7:0])};
        end else if (data_access && auto_inc_q) begin
            cursor_q <= cursor_q + 1'b1;
        end
    end

    // A staged lower cursor byte is used once; a start address byte staged later
    // overwrites the stage, so it no longer belongs to the cursor.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_lo_valid_q <= 1'b0;
        end else if (data_stb) begin
            case (target_q)
                VFDCD_T_CUR_LO: cur_lo_valid_q <= 1'b1;
                VFDCD_T_CUR_HI, VFDCD_T_SA1_LO, VFDCD_T_SA2_LO: cur_lo_valid_q <= 1'b0;
                default: cur_lo_valid_q <= cur_lo_valid_q;
            endcase
        end
    end

    // Display RAM write port.
    always_ff @(posedge hclk) begin
        if (data_stb && target_q == VFDCD_T_WRITE) begin
            ram[cursor_q] <= byte_q;
        end
    end

    // Read pipeline: each read presents the byte fetched by the previous one,
    // so the first read after the command returns 00, since the command clears the latch.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_latch_q <= 8'h00;
            dout_q <= 8'h00;
        end else begin
            if (rd_fall && !port.cs_n && !port.cmd_sel) begin
                dout_q <= rd_latch_q;
            end
            if (rd_stb && target_q == VFDCD_T_READ) begin
                rd_latch_q <= ram[cursor_q];
            end else if (cmd_stb && byte_q == `VFDCD_CMD_READ) begin
                rd_latch_q <= 8'h00;
            end
        end
    end
    assign port.d_dev = dout_q;
    assign port.d_dev_oe = !port.cs_n && !port.rd_n && !port.cmd_sel;

    // Frame timer and refresh scan from the start address.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_cnt_q <= '0;
            scan_cnt_q <= '0;
        end else begin
            scan_cnt_q <= scan_cnt_q + 1'b1;
            if (frame_cnt_q == FCW'(FRAME_CYC - 1)) begin
                frame_cnt_q <= '0;
                scan_cnt_q <= '0;
            end else begin
                frame_cnt_q <= frame_cnt_q + 1'b1;
            end
        end
    end
    assign port.frame_pulse = (frame_cnt_q == '0);

    // Scan reads from the start address; blanking only gates the output.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scan_addr <= '0;
            pixel_byte <= 8'h00;
            display_on <= 1'b0;
        end else begin
            scan_addr <= start1 + ADDR_W'(scan_cnt_q);
            display_on <= port.blank_n;
            pixel_byte <= port.blank_n ? ram[scan_addr] : 8'h00;
        end
    end
endmodule

//--- vfdcd_host.sv
// Host end: AHB-Lite slave that turns register writes into parallel port cycles.
`timescale 1ns/1ps
`include "vfdcd_params.svh"
module vfdcd_host
    import vfdcd_pkg::*;
#(
    parameter int GAP_CYC = `VFDCD_GAP_CYC,
    parameter int STB_CYC = 4
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Blanking control and frame status.
    input wire logic blank_req,
    // Display port.
    vfdcd_if.host port
);
    vfdcd_hstate_t state_q;
    logic [7:0] cnt_q;
    logic ph_act_q;
    logic ph_wr_q;
    logic [31:0] ph_addr_q;
    logic served_q;
    logic port_op;
    logic op_cmd_q;
    logic op_rd_q;
    logic [7:0] op_byte_q;
    logic [7:0] rdata_q;
    logic frame_seen_q;
    logic go;

    // Address phase capture; only writes to CTRL/DATA and reads of RDATA start a cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_act_q <= 1'b0;
            ph_wr_q <= 1'b0;
            ph_addr_q <= 32'h0000_0000;
        end else if (hready) begin
            ph_act_q <= hsel && htrans[1];
            ph_wr_q <= hwrite;
            ph_addr_q <= haddr;
        end
    end
    assign port_op = ph_act_q && (ph_wr_q ? (ph_addr_q == `VFDCD_REG_CTRL ||
        ph_addr_q == `VFDCD_REG_DATA) : (ph_addr_q == `VFDCD_REG_RDATA));

    // One port cycle per data phase; the flag stops a second start while the
    // finished transfer waits for its closing edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            served_q <= 1'b0;
        end else if (go) begin
            served_q <= 1'b1;
        end else if (hready) begin
            served_q <= 1'b0;
        end
    end
    assign go = port_op && !served_q && (state_q == VFDCD_H_IDLE);

    // Port cycle sequencer holds each strobe, then waits the access gap.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= VFDCD_H_IDLE;
            cnt_q <= 8'h00;
            op_cmd_q <= 1'b0;
            op_rd_q <= 1'b0;
            op_byte_q <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            case (state_q)
                VFDCD_H_IDLE: begin
                    if (go) begin
                        op_cmd_q <= ph_addr_q == `VFDCD_REG_CTRL;
                        op_rd_q <= !ph_wr_q;
                        op_byte_q <= hwdata[7:0];
                        cnt_q <= 8'(STB_CYC);
                        state_q <= VFDCD_H_STROBE;
                    end
                end
                VFDCD_H_STROBE: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q == 8'h01) begin
                        if (op_rd_q) begin
                            rdata_q <= port.d_bus;
                        end
                        cnt_q <= 8'(GAP_CYC);
                        state_q <= VFDCD_H_GAP;
                    end
                end
                VFDCD_H_GAP: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q == 8'h01) begin
                        state_q <= VFDCD_H_IDLE;
                    end
                end
                default: state_q <= VFDCD_H_IDLE;
            endcase
        end
    end

    // Frame pulse seen flag; the pulse wins over a status read clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_seen_q <= 1'b0;
        end else if (port.frame_pulse) begin
            frame_seen_q <= 1'b1;
        end else if (ph_act_q && !ph_wr_q && ph_addr_q == `VFDCD_REG_STAT && hready) begin
            frame_seen_q <= 1'b0;
        end
    end

    // A port access stalls its data phase until the strobe and the gap are over.
    assign hreadyout = !(port_op && !(served_q && state_q == VFDCD_H_IDLE));
    assign hresp = 1'b0;
    assign hrdata = {23'h000000, frame_seen_q, rdata_q};

    // Pins: order of bytes is the order of bus writes, so software keeps
    // lower-before-upper and cursor-before-data.
    assign port.cs_n = !(state_q == VFDCD_H_STROBE);
    assign port.wr_n = !(state_q == VFDCD_H_STROBE && !op_rd_q);
    assign port.rd_n = !(state_q == VFDCD_H_STROBE && op_rd_q);
    assign port.cmd_sel = op_cmd_q;
    assign port.d_host = op_byte_q;
    assign port.d_host_oe = state_q == VFDCD_H_STROBE && !op_rd_q;
    assign port.blank_n = !blank_req;
endmodule

//--- vfdcd_sva.sv
// Checker of the parallel port between the host end and the display end.
`timescale 1ns/1ps
module vfdcd_sva #(
    parameter int FRAME_CYC = 100,
    parameter int GAP_CYC = 40
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Port signals.
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic cmd_sel,
    input wire logic [7:0] d_host,
    input wire logic d_host_oe,
    input wire logic d_dev_oe,
    input wire logic frame_pulse
);
    logic [31:0] fcnt_q;
    logic fseen_q;
    logic [31:0] gap_q;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Cycles since the last frame pulse, so a period off by one shows up.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fcnt_q <= 32'h0;
            fseen_q <= 1'b0;
        end else if (frame_pulse) begin
            fcnt_q <= 32'h0;
            fseen_q <= 1'b1;
        end else begin
            fcnt_q <= fcnt_q + 32'h1;
        end
    end
    // Idle cycles of the select line; it starts full because reset counts as a long gap.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_q <= 32'(GAP_CYC);
        end else if (!cs_n) begin
            gap_q <= 32'h0;
        end else if (gap_q < 32'(GAP_CYC)) begin
            gap_q <= gap_q + 32'h1;
        end
    end
    frame_period_a: assert property (frame_pulse && fseen_q |-> fcnt_q == 32'(FRAME_CYC - 1))
        else $error("frame pulse period wrong");
    frame_miss_a: assert property (fseen_q |-> fcnt_q < 32'(FRAME_CYC))
        else $error("frame pulse missing");
    strobe_sel_a: assert property (!wr_n || !rd_n |-> !cs_n)
        else $error("strobe without chip select");
    no_clash_a: assert property (wr_n || rd_n)
        else $error("read and write strobes together");
    wr_len_a: assert property ($fell(wr_n) |-> (!wr_n) [*4] ##1 wr_n)
        else $error("write strobe length wrong");
    rd_len_a: assert property ($fell(rd_n) |-> (!rd_n) [*4] ##1 rd_n)
        else $error("read strobe length wrong");
    access_gap_a: assert property ($fell(cs_n) |-> gap_q >= 32'(GAP_CYC))
        else $error("accesses too close together");
    hold_stable_a: assert property (!wr_n && !$past(wr_n) |-> $stable(cmd_sel) && $stable(d_host))
        else $error("byte or select moved during strobe");
    dev_drive_a: assert property (!cs_n && !rd_n && !cmd_sel |-> d_dev_oe && !d_host_oe)
        else $error("device not alone on bus during a read");
    cmd_write_c: cover property ($rose(wr_n) && cmd_sel);
    data_read_c: cover property ($rose(rd_n) && !cmd_sel);
    frame_c: cover property (frame_pulse && fseen_q);
endmodule

//--- test_vfd_command_decoder.sv
// Testbench joining the host end and the display end of the decoder link.
`timescale 1ns/1ps
`include "vfdcd_params.svh"
module test_vfd_command_decoder import vfdcd_pkg::*;;
    localparam int FRAME = 100;
    localparam logic [7:0] WB [3] = '{8'ha1, 8'h1b, 8'hc3};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic blank_req = 1'b0;
    logic hreadyout, hresp, rdy_s, display_on;
    logic [31:0] hrdata, rd_s, rv;
    logic [12:0] start1, start2, scan_addr;
    logic [1:0] lum_level;
    logic [7:0] pixel_byte;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    vfdcd_if bus();
    vfdcd_device #(.FRAME_CYC(FRAME)) u_vfdcd_device (.hclk(hclk), .hresetn(hresetn),
        .port(bus.device), .start1(start1), .start2(start2), .lum_level(lum_level),
        .display_on(display_on), .pixel_byte(pixel_byte), .scan_addr(scan_addr));
    vfdcd_host u_vfdcd_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .blank_req(blank_req),
        .port(bus.host));
    vfdcd_sva #(.FRAME_CYC(FRAME), .GAP_CYC(`VFDCD_GAP_CYC)) u_vfdcd_sva (.hclk(hclk),
        .hresetn(hresetn), .cs_n(bus.cs_n), .wr_n(bus.wr_n), .rd_n(bus.rd_n),
        .cmd_sel(bus.cmd_sel), .d_host(bus.d_host), .d_host_oe(bus.d_host_oe),
        .d_dev_oe(bus.d_dev_oe),
        .frame_pulse(bus.frame_pulse));
    always #25 hclk = ~hclk;
    // Bus answers are captured mid-cycle, so the edge that takes them never races them.
    always @(negedge hclk) begin
        rdy_s = hreadyout;
        rd_s = hrdata;
    end
    // A hang is cut off well beyond the few thousand cycles the tests need.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk_addr(input string what, input logic [12:0] exp, input logic [12:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One single AHB-Lite transfer; the slave stalls for the whole port cycle.
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (rdy_s !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (rdy_s !== 1'b1) @(posedge hclk);
        rv = rd_s;
    endtask
    task automatic cmd(input logic [7:0] b);
        ahb(1'b1, `VFDCD_REG_CTRL, {24'h0, b});
    endtask
    task automatic dat(input logic [7:0] b);
        ahb(1'b1, `VFDCD_REG_DATA, {24'h0, b});
    endtask
    task automatic rd();
        ahb(1'b0, `VFDCD_REG_RDATA, 32'h0);
    endtask
    // Lower byte first; the ignored top bits of the upper byte are set to ones.
    task automatic set_addr(input logic [7:0] lo_cmd, input logic [12:0] a);
        cmd(lo_cmd);
        dat(a[7:0]);
        cmd(lo_cmd + 8'h1);
        dat({3'b111, a[12:8]});
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk_byte("luminance at reset", 8'h0, {6'h0, lum_level});
        chk_byte("response", 8'h0, {7'h0, hresp});
        @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            cmd(`VFDCD_LUM_BASE + 8'((i + 3) % 4));
            chk_byte("luminance", 8'((i + 3) % 4), {6'h0, lum_level});
        end
        $display("test luminance done");
        for (int k = 0; k < 2; k++) begin
            cmd(`VFDCD_CMD_SA1_LO + 8'(2 * k));
            dat(8'h5a + 8'(k));
            chk_addr("start staged", 13'h0, (k == 0) ? start1 : start2);
            cmd(`VFDCD_CMD_SA1_HI + 8'(2 * k));
            dat(8'hf3 - 8'(k));
            chk_addr("start", 13'h135a - 13'(k * 'hff), (k == 0) ? start1 : start2);
        end
        $display("test start address done");
        // Codes 07, 13 and 1f lie outside every command group.
        foreach (WB[i]) begin
            cmd(8'h07 + 8'(i * 12));
            chk_byte("luminance kept", 8'h2, {6'h0, lum_level});
            chk_addr("start kept", 13'h135a, start1);
        end
        $display("test unknown command done");
        set_addr(`VFDCD_CMD_CUR_LO, 13'h1234);
        cmd(`VFDCD_CMD_INC);
        cmd(`VFDCD_CMD_WRITE);
        foreach (WB[i]) dat(WB[i]);
        chk_byte("data not a command", 8'h2, {6'h0, lum_level});
        set_addr(`VFDCD_CMD_CUR_LO, 13'h1234);
        cmd(`VFDCD_CMD_READ);
        rd();
        foreach (WB[i]) begin
            rd();
            chk_byte("read back", WB[i], rv[7:0]);
        end
        $display("test increment done");
        cmd(`VFDCD_CMD_NOINC);
        set_addr(`VFDCD_CMD_CUR_LO, 13'h0100);
        cmd(`VFDCD_CMD_WRITE);
        dat(8'h11);
        dat(8'h22);
        cmd(`VFDCD_CMD_CUR_HI);
        dat(8'h01);
        cmd(`VFDCD_CMD_READ);
        rd();
        repeat (2) begin
            rd();
            chk_byte("no increment", 8'h22, rv[7:0]);
        end
        $display("test no increment done");
        blank_req <= 1'b1;
        repeat (5) @(posedge hclk);
        @(negedge hclk);
        chk_byte("display off", 8'h0, {7'h0, display_on});
        chk_byte("pixels off", 8'h0, pixel_byte);
        @(posedge hclk);
        blank_req <= 1'b0;
        repeat (5) @(posedge hclk);
        @(negedge hclk);
        chk_byte("display on", 8'h1, {7'h0, display_on});
        chk_byte("luminance after blank", 8'h2, {6'h0, lum_level});
        chk_addr("start after blank", 13'h125b, start2);
        @(posedge hclk);
        set_addr(`VFDCD_CMD_CUR_LO, 13'h1235);
        cmd(`VFDCD_CMD_READ);
        rd();
        rd();
        chk_byte("memory after blank", 8'h1b, rv[7:0]);
        $display("test blanking done");
        // Start right after a pulse so no new pulse falls between the two status reads.
        @(negedge hclk);
        while (bus.frame_pulse !== 1'b1) @(negedge hclk);
        @(posedge hclk);
        ahb(1'b0, `VFDCD_REG_STAT, 32'h0);
        chk_byte("frame seen", 8'h1, {7'h0, rv[8]});
        ahb(1'b0, `VFDCD_REG_STAT, 32'h0);
        chk_byte("frame seen cleared", 8'h0, {7'h0, rv[8]});
        $display("test frame status done");
        close_out();
    end
endmodule
